// ==== inc/ueb_defs.vh ====
// Constants for the asynchronous serial error status and baud generator block
`ifndef UEB_DEFS_VH
`define UEB_DEFS_VH

// ====================================================================
// Register addresses
`define UEB_ADDR_ASYNC_MODE 16'hFF70
`define UEB_ADDR_ERR_STATUS 16'hFF71
`define UEB_ADDR_SYNC_MODE 16'hFF72
`define UEB_ADDR_BAUD_SEL 16'hFF73
`define UEB_ADDR_RX_BUFFER 16'hFF74
`define UEB_ADDR_TX_DATA 16'hFF75

// ====================================================================
// Reset values
`define UEB_RST_BYTE 8'h00

// ====================================================================
// Field positions
`define UEB_AM_TX_EN 7
`define UEB_AM_RX_EN 6
`define UEB_AM_PAR_HI 5
`define UEB_AM_PAR_LO 4
`define UEB_AM_CHAR_LEN 3
`define UEB_AM_STOP_LEN 2
`define UEB_SM_SYNC_EN 7
`define UEB_SM_BIT_ORDER 2
`define UEB_SM_CLK_SEL 1
`define UEB_ES_PARITY 2
`define UEB_ES_FRAMING 1
`define UEB_ES_OVERRUN 0
`define UEB_BS_SEL_HI 7
`define UEB_BS_SEL_LO 4

// ====================================================================
// Parity modes and clock codes
`define UEB_PAR_NONE 2'h0
`define UEB_PAR_ZERO 2'h1
`define UEB_PAR_ODD 2'h2
`define UEB_PAR_EVEN 2'h3
`define UEB_CLK_EXT 4'h8
`define UEB_CLK_SYS_MAX 4'h7

// ====================================================================
// Timing counts
`define UEB_SAMPLES_PER_BIT 4'h8
`define UEB_SAMPLE_MID 4'h4
`define UEB_EXT_DIV 2

`endif

// ==== src/ueb_baud_gen.v ====
// Baud sample-tick generator: prescaler select then a fixed divide by two
`timescale 1ns/1ps
`default_nettype none
`include "ueb_defs.vh"

module ueb_baud_gen (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Control
    input wire [3:0] clockSelect,
    input wire restart,
    input wire extClkIn,
    // Output: one pulse per sample, eight samples per bit
    output reg sampleTick
);

    // ====================================================================
    // Prescaler
    reg [7:0] prescale;
    reg extLast;
    reg halfDiv;
    reg srcTick;
    wire [2:0] selLow;
    assign selLow = clockSelect[2:0];

    // Source pulse: fx/2^n, n = code + 1, or a rising edge of the pin
    always @* begin
        if (clockSelect == `UEB_CLK_EXT) begin
            srcTick = extClkIn & ~extLast;
        end else if (clockSelect <= `UEB_CLK_SYS_MAX) begin
            srcTick = &(prescale | ~((8'h02 << selLow) - 8'h01));
        end else begin
            srcTick = 1'b0;
        end
    end

    // Restart keeps a mid-frame rewrite from leaving a stale phase behind
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 8'h00;
            extLast <= 1'b0;
            halfDiv <= 1'b0;
            sampleTick <= 1'b0;
        end else begin
            extLast <= extClkIn;
            if (restart) begin
                prescale <= 8'h00;
                halfDiv <= 1'b0;
                sampleTick <= 1'b0;
            end else begin
                prescale <= prescale + 8'h01;
                // Divide by two then eight samples per bit gives fx/(2^(n+1)*8) or ext/16
                if (srcTick) begin
                    halfDiv <= ~halfDiv;
                end
                sampleTick <= srcTick & halfDiv;
            end
        end
    end

endmodule
`default_nettype wire

// ==== src/ueb_top.v ====
// Asynchronous serial port: registers, receiver with error status, transmitter
`timescale 1ns/1ps
`default_nettype none
`include "ueb_defs.vh"

module ueb_top (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // CPU register port
    input wire [15:0] cpuAddr,
    input wire cpuWr,
    input wire cpuRd,
    input wire [7:0] cpuWdata,
    output reg [7:0] cpuRdata,
    // Serial pins
    input wire rxdIn,
    input wire asckIn,
    output reg txdOut,
    output wire txdOe,
    // Pins left free for general port use
    output wire rxdPinFree,
    output wire txdPinFree,
    output wire asckPinFree,
    // Status
    output wire txBusy,
    output reg rxDone
);

    // ====================================================================
    // Registers
    reg [7:0] asyncMode;
    reg [7:0] syncMode;
    reg [3:0] baudSelect;
    reg [2:0] errStatus;
    reg [7:0] rxBuffer;
    reg rxFull;

    wire wrAsync = cpuWr && (cpuAddr == `UEB_ADDR_ASYNC_MODE);
    wire wrSync = cpuWr && (cpuAddr == `UEB_ADDR_SYNC_MODE);
    wire wrBaud = cpuWr && (cpuAddr == `UEB_ADDR_BAUD_SEL);
    wire wrTx = cpuWr && (cpuAddr == `UEB_ADDR_TX_DATA);
    wire rdRxBuf = cpuRd && (cpuAddr == `UEB_ADDR_RX_BUFFER);

    wire txEnable = asyncMode[`UEB_AM_TX_EN];
    wire rxEnable = asyncMode[`UEB_AM_RX_EN];
    wire [1:0] parMode = asyncMode[`UEB_AM_PAR_HI:`UEB_AM_PAR_LO];
    wire charLen8 = asyncMode[`UEB_AM_CHAR_LEN];
    wire stopLen2 = asyncMode[`UEB_AM_STOP_LEN];
    // Async mode requires the sync-mode bits clear
    wire asyncOk = (syncMode == `UEB_RST_BYTE);
    wire extClk = (baudSelect == `UEB_CLK_EXT);

    // ====================================================================
    // Pin usage
    assign txdOe = txEnable && asyncOk;
    assign txdPinFree = !txdOe;
    assign rxdPinFree = !(rxEnable && asyncOk);
    assign asckPinFree = !(extClk && (txEnable || rxEnable));

    // ====================================================================
    // Baud generator
    wire sampleTick;

    ueb_baud_gen baudGen (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clockSelect(baudSelect),
        .restart(wrBaud),
        .extClkIn(asckIn),
        .sampleTick(sampleTick)
    );

    // ====================================================================
    // Register writes and read data
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            asyncMode <= `UEB_RST_BYTE;
            syncMode <= `UEB_RST_BYTE;
            baudSelect <= 4'h0;
            cpuRdata <= `UEB_RST_BYTE;
        end else begin
            if (wrAsync) begin
                asyncMode <= {cpuWdata[7:2], 2'b00};
            end
            if (wrSync) begin
                syncMode <= {cpuWdata[7], 4'h0, cpuWdata[2:1], 1'b0};
            end
            if (wrBaud) begin
                baudSelect <= cpuWdata[`UEB_BS_SEL_HI:`UEB_BS_SEL_LO];
            end
            if (cpuRd) begin
                case (cpuAddr)
                    `UEB_ADDR_ASYNC_MODE: cpuRdata <= asyncMode;
                    `UEB_ADDR_ERR_STATUS: cpuRdata <= {5'h00, errStatus};
                    `UEB_ADDR_SYNC_MODE: cpuRdata <= syncMode;
                    `UEB_ADDR_BAUD_SEL: cpuRdata <= {baudSelect, 4'h0};
                    `UEB_ADDR_RX_BUFFER: cpuRdata <= rxBuffer;
                    default: cpuRdata <= `UEB_RST_BYTE;
                endcase
            end
        end
    end

    // ====================================================================
    // Receiver
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_BITS = 2'h2;
    localparam RX_STOP = 2'h3;

    reg [1:0] rxState;
    reg [2:0] rxSampleCnt;
    reg [3:0] rxBitCnt;
    reg [8:0] rxShift;
    wire rxOn = rxEnable && asyncOk;
    wire [3:0] rxDataBits = charLen8 ? 4'h8 : 4'h7;
    wire rxHasPar = (parMode != `UEB_PAR_NONE);
    wire [3:0] rxTotal = rxDataBits + {3'h0, rxHasPar};
    wire rxMid = sampleTick && (rxSampleCnt == 3'h7);
    // Bits enter at the top: a parity bit ends in bit 8 and pushes the data one place lower
    wire [7:0] rxData = charLen8 ? rxShift[8:1] : {1'b0, rxShift[8:2]};
    wire rxParBit = rxShift[8];
    wire [7:0] rxWithPar = charLen8 ? rxShift[7:0] : {1'b0, rxShift[7:1]};
    wire rxDataPar = ^rxWithPar;
    reg rxParErr;

    always @* begin
        case (parMode)
            `UEB_PAR_ODD: rxParErr = ~(rxDataPar ^ rxParBit);
            `UEB_PAR_EVEN: rxParErr = rxDataPar ^ rxParBit;
            default: rxParErr = 1'b0;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxState <= RX_IDLE;
            rxSampleCnt <= 3'h0;
            rxBitCnt <= 4'h0;
            rxShift <= 9'h000;
            rxBuffer <= `UEB_RST_BYTE;
            rxFull <= 1'b0;
            errStatus <= 3'h0;
            rxDone <= 1'b0;
        end else begin
            rxDone <= 1'b0;
            if (rdRxBuf) begin
                rxFull <= 1'b0;
            end
            if (sampleTick) begin
                rxSampleCnt <= rxSampleCnt + 3'h1;
            end
            case (rxState)
                RX_IDLE: begin
                    if (rxOn && sampleTick && !rxdIn) begin
                        rxState <= RX_START;
                        rxSampleCnt <= 3'h4;
                    end
                end
                RX_START: begin
                    if (rxMid) begin
                        rxState <= rxdIn ? RX_IDLE : RX_BITS;
                        rxBitCnt <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (rxMid) begin
                        // LSB first: shift in from the top
                        rxShift <= {rxdIn, rxShift[8:1]};
                        rxBitCnt <= rxBitCnt + 4'h1;
                        if (rxBitCnt + 4'h1 == rxTotal) begin
                            rxState <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is checked
                    if (rxMid) begin
                        rxState <= RX_IDLE;
                        rxDone <= 1'b1;
                        errStatus[`UEB_ES_FRAMING] <= !rxdIn;
                        errStatus[`UEB_ES_PARITY] <= rxHasPar && rxParErr;
                        // A read in this same cycle frees the buffer in time
                        if (rxFull && !rdRxBuf) begin
                            errStatus[`UEB_ES_OVERRUN] <= 1'b1;
                        end else begin
                            errStatus[`UEB_ES_OVERRUN] <= 1'b0;
                            rxBuffer <= rxHasPar ? rxWithPar : rxData;
                            rxFull <= 1'b1;
                        end
                    end
                end
                default: rxState <= RX_IDLE;
            endcase
            // Sync mode: status left as is, its content is not meaningful
            if (!rxOn) begin
                rxState <= RX_IDLE;
            end
        end
    end

    // ====================================================================
    // Transmitter
    reg txActive;
    reg [11:0] txShift;
    reg [3:0] txBitsLeft;
    reg [2:0] txSampleCnt;
    reg txParity;
    wire [7:0] txChar = charLen8 ? cpuWdata : {1'b0, cpuWdata[6:0]};

    always @* begin
        case (parMode)
            `UEB_PAR_ODD: txParity = ~^txChar;
            `UEB_PAR_EVEN: txParity = ^txChar;
            default: txParity = 1'b0;
        endcase
    end

    assign txBusy = txActive;

    // Frame is assembled LSB first: start, data, optional parity, stop bits
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            txActive <= 1'b0;
            txShift <= 12'hFFF;
            txBitsLeft <= 4'h0;
            txSampleCnt <= 3'h0;
            txdOut <= 1'b1;
        end else begin
            if (!txActive) begin
                txdOut <= 1'b1;
                if (wrTx && txdOe) begin
                    txActive <= 1'b1;
                    txSampleCnt <= 3'h0;
                    txBitsLeft <= 4'h2 + (charLen8 ? 4'h8 : 4'h7) +
                        {3'h0, parMode != `UEB_PAR_NONE} + {3'h0, stopLen2};
                    if (charLen8) begin
                        txShift <= (parMode != `UEB_PAR_NONE) ?
                            {2'b11, txParity, txChar, 1'b0} : {3'b111, txChar, 1'b0};
                    end else begin
                        txShift <= (parMode != `UEB_PAR_NONE) ?
                            {3'b111, txParity, txChar[6:0], 1'b0} :
                            {4'hF, txChar[6:0], 1'b0};
                    end
                end
            end else if (sampleTick) begin
                txdOut <= txShift[0];
                txSampleCnt <= txSampleCnt + 3'h1;
                if (txSampleCnt == 3'h7) begin
                    txShift <= {1'b1, txShift[11:1]};
                    txBitsLeft <= txBitsLeft - 4'h1;
                    if (txBitsLeft == 4'h1) begin
                        txActive <= 1'b0;
                    end
                end
            end
            // A cut frame must not leave the line parked low
            if (!txdOe) begin
                txActive <= 1'b0;
                txdOut <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== verif/ueb_top_asserts.sv ====
// Checker on the serial port's register port and pin-use outputs
`timescale 1ns/1ps
`default_nettype none
module ueb_top_asserts (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // CPU register port
    input wire [15:0] cpuAddr,
    input wire cpuWr,
    input wire cpuRd,
    input wire [7:0] cpuWdata,
    input wire [7:0] cpuRdata,
    // Serial pins
    input wire rxdIn,
    input wire asckIn,
    input wire txdOut,
    input wire txdOe,
    // Pin use and status
    input wire rxdPinFree,
    input wire txdPinFree,
    input wire asckPinFree,
    input wire txBusy,
    input wire rxDone
);
    // ====================
    // Shadow of the mode bits, so pin use can be judged from bus traffic alone
    reg [1:0] asyncEn;
    reg syncOn;
    reg [3:0] clkCode;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            asyncEn <= 2'h0;
            syncOn <= 1'b0;
            clkCode <= 4'h0;
        end else if (cpuWr) begin
            if (cpuAddr == 16'hFF70) asyncEn <= cpuWdata[7:6];
            if (cpuAddr == 16'hFF72) syncOn <= |(cpuWdata & 8'h86);
            if (cpuAddr == 16'hFF73) clkCode <= cpuWdata[7:4];
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ====================
    // Properties
    property p_statusUpper; cpuRd && cpuAddr == 16'hFF71 |=> cpuRdata[7:3] == 5'h00; endproperty
    a_statusUpper: assert property (p_statusUpper) else $error("status upper bits set");
    property p_baudRead; cpuRd && cpuAddr == 16'hFF73 |=> cpuRdata == {$past(clkCode), 4'h0}; endproperty
    a_baudRead: assert property (p_baudRead) else $error("baud select readback wrong");
    property p_rdHold; !cpuRd |=> $stable(cpuRdata); endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data moved without a read");
    property p_donePulse; rxDone |=> !rxDone; endproperty
    a_donePulse: assert property (p_donePulse) else $error("reception end not a pulse");
    property p_txdIdle; !txBusy |-> txdOut; endproperty
    a_txdIdle: assert property (p_txdIdle) else $error("transmit line low while idle");
    property p_txdOe; txdOe == (asyncEn[1] && !syncOn); endproperty
    a_txdOe: assert property (p_txdOe) else $error("transmit drive enable wrong");
    property p_rxdFree; !syncOn |-> rxdPinFree == !asyncEn[0]; endproperty
    a_rxdFree: assert property (p_rxdFree) else $error("receive pin use wrong");
    property p_txdFree; !syncOn |-> txdPinFree == !asyncEn[1]; endproperty
    a_txdFree: assert property (p_txdFree) else $error("transmit pin use wrong");
    property p_asckFree; !syncOn |-> asckPinFree == !(clkCode == 4'h8 && |asyncEn); endproperty
    a_asckFree: assert property (p_asckFree) else $error("baud clock pin use wrong");
endmodule
bind ueb_top ueb_top_asserts u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd),
    .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .rxdIn(rxdIn), .asckIn(asckIn),
    .txdOut(txdOut), .txdOe(txdOe), .rxdPinFree(rxdPinFree), .txdPinFree(txdPinFree),
    .asckPinFree(asckPinFree), .txBusy(txBusy), .rxDone(rxDone)
);
`default_nettype wire

// ==== verif/ueb_remote.sv ====
// Remote serial transmitter feeding the device's receive line
`timescale 1ns/1ps
`default_nettype none
module ueb_remote (
    // Serial line towards the device
    output var logic rxLine
);
    initial rxLine = 1'b1;
    // Timed in ns, so its phase is unrelated to the device clock
    task automatic sendFrame(input logic [7:0] d, input int nb, input bit parOn,
        input bit par, input bit stopVal, input int bitNs);
        int b;
        rxLine = 1'b0;
        #(bitNs);
        for (b = 0; b < nb; b++) begin
            rxLine = d[b];
            #(bitNs);
        end
        if (parOn) begin
            rxLine = par;
            #(bitNs);
        end
        rxLine = stopVal;
        #(bitNs);
        rxLine = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_uart_error_status_and_baud_gen.sv ====
// Self-checking bench for the serial error status and baud generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_uart_error_status_and_baud_gen;
    logic sys_clk, rst_n, cpuWr, cpuRd, rxdIn, asckIn, txdOut, txBusy, rxDone;
    logic [15:0] cpuAddr;
    logic [7:0] cpuWdata, cpuRdata, rdVal;
    int failures = 0;
    int checks = 0;
    int n, i, k;
    // Rows: mode, sent data, parity bit, stop bit, expected status
    logic [20:0] rows [0:5] = '{{8'h48, 8'hA5, 1'b0, 1'b1, 3'h0}, {8'h78, 8'hA5, 1'b1, 1'b1, 3'h4},
        {8'h68, 8'hA5, 1'b1, 1'b1, 3'h0}, {8'h58, 8'hA5, 1'b1, 1'b1, 3'h0},
        {8'h60, 8'hD3, 1'b1, 1'b1, 3'h0}, {8'h4C, 8'h3C, 1'b0, 1'b0, 3'h2}};
    ueb_top u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd),
        .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .rxdIn(rxdIn), .asckIn(asckIn),
        .txdOut(txdOut), .txdOe(), .rxdPinFree(), .txdPinFree(), .asckPinFree(),
        .txBusy(txBusy), .rxDone(rxDone)
    );
    ueb_remote u_remote (.rxLine(rxdIn));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // External baud clock runs free, twelve system clocks a period
    initial begin
        asckIn = 1'b0;
        forever begin
            repeat (6) @(posedge sys_clk);
            #1 asckIn = ~asckIn;
        end
    end
    // ====================
    // Bus tasks
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1 cpuAddr = a;
        cpuWdata = d;
        cpuWr = 1'b1;
        @(posedge sys_clk) #1 cpuWr = 1'b0;
    endtask
    task automatic chkRd(input logic [15:0] a, input logic [7:0] e, input string nm);
        @(posedge sys_clk) #1 cpuAddr = a;
        cpuRd = 1'b1;
        @(posedge sys_clk) #1 cpuRd = 1'b0;
        rdVal = cpuRdata;
        `CHK(nm, e, rdVal)
    endtask
    // Code 0 gives 32 clocks a bit, so one frame fits well inside the wait
    task automatic rxOne(input logic [7:0] d, input int nb, input bit parOn, input bit par,
        input bit stopVal);
        fork
            u_remote.sendFrame(d, nb, parOn, par, stopVal, 160);
            begin
                for (k = 0; k < 600 && rxDone !== 1'b1; k++) @(posedge sys_clk) #1;
                `CHK("rxDone", 1'b1, rxDone)
            end
        join
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #300000;
        failures++;
        give_verdict;
    end
    // ====================
    // Main sequence
    initial begin
        cpuAddr = 16'h0000;
        cpuWdata = 8'h00;
        cpuWr = 1'b0;
        cpuRd = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chkRd(16'hFF71, 8'h00, "status reset");
        chkRd(16'hFF73, 8'h00, "baud reset");
        wr(16'hFF73, 8'h7F);
        chkRd(16'hFF73, 8'h70, "baud field");
        wr(16'hFF71, 8'hFF);
        chkRd(16'hFF71, 8'h00, "status read only");
        chkRd(16'hFF7F, 8'h00, "unmapped");
        wr(16'hFF73, 8'h00);
        for (i = 0; i < 6; i++) begin
            wr(16'hFF70, rows[i][20:13]);
            rxOne(rows[i][12:5], rows[i][16] ? 8 : 7, rows[i][18:17] != 2'h0, rows[i][4],
                rows[i][3]);
            chkRd(16'hFF71, {5'h00, rows[i][2:0]}, "status");
            chkRd(16'hFF74, {rows[i][16] & rows[i][12], rows[i][11:5]}, "buffer");
        end
        // Two stop bits set for transmit, yet frames arrive with one
        wr(16'hFF70, 8'h4C);
        rxOne(8'h11, 8, 0, 0, 1);
        rxOne(8'h22, 8, 0, 0, 1);
        chkRd(16'hFF71, 8'h01, "overrun");
        rxOne(8'h33, 8, 0, 0, 1);
        chkRd(16'hFF71, 8'h01, "overrun again");
        chkRd(16'hFF74, 8'h11, "kept char");
        rxOne(8'h44, 8, 0, 0, 1);
        chkRd(16'hFF71, 8'h00, "after read");
        chkRd(16'hFF74, 8'h44, "new char");
        rxOne(8'h55, 8, 0, 0, 0);
        chkRd(16'hFF74, 8'h55, "framing char");
        // Start bit width gives the bit time; FE also shows the low bit goes first
        wr(16'hFF70, 8'h88);
        for (i = 0; i < 4; i++) begin
            n = (i == 3) ? 8 : i * 2;
            wr(16'hFF73, {n[3:0], 4'h0});
            wr(16'hFF75, (i == 0) ? 8'hFE : 8'hFF);
            k = (i == 3) ? 192 : (32 << n) * ((i == 0) ? 2 : 1);
            for (n = 0; n < 99 && txdOut !== 1'b0; n++) @(posedge sys_clk) #1;
            for (n = 0; n < 9999 && txdOut === 1'b0; n++) @(posedge sys_clk) #1;
            `CHK("bit width", k, n)
            for (n = 0; n < 99999 && txBusy === 1'b1; n++) @(posedge sys_clk) #1;
        end
        // Any of sync-mode bits 7, 2, 1 takes the transmit pin away and refuses new characters
        wr(16'hFF72, 8'hFF);
        chkRd(16'hFF72, 8'h86, "sync reserved");
        wr(16'hFF75, 8'h00);
        `CHK("tx refused", 1'b0, txBusy)
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chkRd(16'hFF71, 8'h00, "status second reset");
        chkRd(16'hFF73, 8'h00, "baud second reset");
        give_verdict;
    end
endmodule
`default_nettype wire
